/* rtl/isl_pkg.sv */
// Shared types and constants for interface selection and status LED
package isl_pkg;

  // ==========================================================
  // Interface codes and header pin positions
  typedef enum logic [1:0] {
    IF_I2C  = 2'h0,
    IF_SPI  = 2'h1,
    IF_UART = 2'h2,
    IF_USB  = 2'h3
  } isl_if_t;

  localparam int PIN_SCK_SDA = 0;
  localparam int PIN_MISO_SCL = 1;
  localparam int PIN_CS_URX = 2;
  localparam int PIN_MOSI_UTX = 3;

  // ==========================================================
  // Timing, figures in their own unit, then cycles at 10 MHz
  localparam int CLK_HZ = 10000000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int DEB_MS = 20;
  localparam int HOLD_MS = 1000;
  localparam int BLINK_MS = 200;
  localparam int PAUSE_MS = 1000;
  localparam int SETTLE_MS = 300;
  localparam int RECENT_MS = 500;
  localparam int FAST_HZ = 7;
  localparam int SLOW_HZ = 1;
  localparam int ERR_HZ = 10;

  localparam logic [23:0] DEB_CYC = 24'(DEB_MS * CYC_PER_MS);
  localparam logic [23:0] HOLD_CYC = 24'(HOLD_MS * CYC_PER_MS);
  localparam logic [23:0] BLINK_CYC = 24'(BLINK_MS * CYC_PER_MS);
  localparam logic [23:0] PAUSE_CYC = 24'(PAUSE_MS * CYC_PER_MS);
  localparam logic [23:0] SETTLE_CYC = 24'(SETTLE_MS * CYC_PER_MS);
  localparam logic [23:0] RECENT_CYC = 24'(RECENT_MS * CYC_PER_MS);
  localparam logic [23:0] HALF_FAST = 24'(CLK_HZ / (2 * FAST_HZ));
  localparam logic [23:0] HALF_SLOW = 24'(CLK_HZ / (2 * SLOW_HZ));
  localparam logic [23:0] HALF_ERR = 24'(CLK_HZ / (2 * ERR_HZ));
  localparam logic [23:0] BOOT_MARGIN = 24'h000004;

  // ==========================================================
  // Control states
  typedef enum logic [8:0] {
    ST_BOOT    = 9'h001,
    ST_HOLD    = 9'h002,
    ST_OFFER   = 9'h004,
    ST_PRESS   = 9'h008,
    ST_COMMIT  = 9'h010,
    ST_WRITE   = 9'h020,
    ST_SETTLE  = 9'h040,
    ST_RUN     = 9'h080,
    ST_FWLOAD  = 9'h100
  } isl_state_t;

  // LED pattern kinds
  typedef enum logic [1:0] {
    PAT_OFF   = 2'h0,
    PAT_SOLID = 2'h1,
    PAT_BURST = 2'h2,
    PAT_FLASH = 2'h3
  } isl_pat_t;

  typedef struct packed {
    isl_pat_t kind;
    logic [2:0] count;
    logic [23:0] half;
  } isl_pattern_t;

  // ==========================================================
  // Signal groups toward the pins and the protocol cores
  typedef struct packed {
    logic [3:0] drive;
    logic [3:0] oeN;
  } isl_pins_t;

  typedef struct packed {
    logic sdaLow;
    logic sclLow;
    logic spiMiso;
    logic uartTx;
  } isl_core_out_t;

  typedef struct packed {
    logic sdaIn;
    logic sclIn;
    logic spiSck;
    logic spiCs;
    logic spiMosi;
    logic uartRx;
  } isl_core_in_t;

endpackage : isl_pkg

/* rtl/isl_debounce.sv */
// Button synchroniser and debouncer
`timescale 1ns/1ps
module isl_debounce #(
  parameter logic [23:0] STABLE_CYC = isl_pkg::DEB_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Raw button and clean level
  input wire logic rawIn,
  output logic level
);

  logic sync1;
  logic sync2;
  logic [23:0] cnt;
  logic [23:0] next_cnt;
  logic next_level;

  // ==========================================================
  // Level changes only after a stable run of STABLE_CYC cycles
  always_comb
  begin
    next_cnt = 24'h000000;
    next_level = level;
    if (sync2 != level)
    begin
      if (cnt >= STABLE_CYC - 24'h000001)
      begin
        next_level = sync2;
      end
      else
      begin
        next_cnt = cnt + 24'h000001;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      cnt <= 24'h000000;
      level <= 1'b0;
    end
    else
    begin
      sync1 <= rawIn;
      sync2 <= sync1;
      cnt <= next_cnt;
      level <= next_level;
    end
  end

endmodule : isl_debounce

/* rtl/isl_status_top.sv */
// Interface selection, pin routing and status LED control
// Summary of operation
// - Exactly one host interface enabled at once
// - Stored interface read back at every power-up
// - Blank storage selects I2C
// - Button held at power-up: LED steady
// - Selection: burst then pause names offer
// - Short press advances offered interface
// - Burst length one to four per interface
// - Long hold commits; LED solid acknowledges
// - Release stores choice, then new burst
// - Running: repeated burst shows ready interface
// - Recent bus traffic flashes at 7 Hz
// - Old traffic only flashes at 1 Hz
// - Internal error flashes at 10 Hz
// - Shared header pins follow active interface
// - External reset input is active low
// - Boot button with USB: load, LED off
// - Load done restarts with stored burst
`timescale 1ns/1ps
module isl_status_top #(
  parameter logic [23:0] DEB_CYC = isl_pkg::DEB_CYC,
  parameter logic [23:0] HOLD_CYC = isl_pkg::HOLD_CYC,
  parameter logic [23:0] BLINK_CYC = isl_pkg::BLINK_CYC,
  parameter logic [23:0] PAUSE_CYC = isl_pkg::PAUSE_CYC,
  parameter logic [23:0] SETTLE_CYC = isl_pkg::SETTLE_CYC,
  parameter logic [23:0] RECENT_CYC = isl_pkg::RECENT_CYC,
  parameter logic [23:0] HALF_FAST = isl_pkg::HALF_FAST,
  parameter logic [23:0] HALF_SLOW = isl_pkg::HALF_SLOW,
  parameter logic [23:0] HALF_ERR = isl_pkg::HALF_ERR
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic extRst_n,
  // Buttons and board status
  input wire logic modeButton,
  input wire logic boot_select_button,
  input wire logic usbConnected,
  input wire logic busActivity,
  input wire logic errorDetect,
  input wire logic fwLoadDone,
  // Non-volatile storage
  input wire logic nvDone,
  input wire logic nvValid,
  input wire logic [1:0] nvData,
  output logic nvReadReq,
  output logic nvWriteReq,
  output logic [1:0] nvWriteData,
  // Protocol cores
  input wire isl_pkg::isl_core_out_t coreOut,
  output isl_pkg::isl_core_in_t coreIn,
  // Shared header pins
  input wire logic [3:0] pinIn,
  output isl_pkg::isl_pins_t pins,
  // Status
  output logic led,
  output logic [3:0] ifEnable,
  output logic fwLoadMode
);

  isl_pkg::isl_state_t state, next_state;
  logic [23:0] timer, next_timer;
  isl_pkg::isl_if_t activeIf, next_activeIf;
  isl_pkg::isl_if_t offered, next_offered;
  logic next_nvReadReq, next_nvWriteReq, next_fwLoadMode;
  logic [1:0] next_nvWriteData;
  logic [3:0] next_ifEnable;
  logic seen, next_seen, errFlag, next_errFlag;
  logic [23:0] recent, next_recent;
  logic modeLevel, bootLevel, extSync1, extSync2;
  isl_pkg::isl_pattern_t pat, prevPat;
  logic [23:0] ledTimer, next_ledTimer;
  logic [3:0] ledStep, next_ledStep;
  logic next_led;
  isl_pkg::isl_pins_t next_pins;
  isl_pkg::isl_core_in_t next_coreIn;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Button conditioning
  isl_debounce #(.STABLE_CYC(DEB_CYC)) u_modeDeb (
    .clk(clk),
    .rst(rst),
    .rawIn(modeButton),
    .level(modeLevel)
  );

  isl_debounce #(.STABLE_CYC(DEB_CYC)) u_bootDeb (
    .clk(clk),
    .rst(rst),
    .rawIn(boot_select_button),
    .level(bootLevel)
  );

  // ==========================================================
  // Selection and startup control
  always_comb
  begin
    next_state = state;
    next_timer = timer + 24'h000001;
    next_activeIf = activeIf;
    next_offered = offered;
    next_nvReadReq = 1'b0;
    next_nvWriteReq = 1'b0;
    next_nvWriteData = nvWriteData;
    next_fwLoadMode = 1'b0;
    next_seen = seen | busActivity;
    next_errFlag = errFlag | errorDetect;
    next_recent = busActivity ? RECENT_CYC :
                  (recent != 24'h000000 ? recent - 24'h000001 : recent);
    case (state)
      isl_pkg::ST_BOOT:
      begin
        next_nvReadReq = ~nvDone;
        if (nvDone && timer >= DEB_CYC + isl_pkg::BOOT_MARGIN)
        begin
          next_activeIf = nvValid ? isl_pkg::isl_if_t'(nvData)
                                  : isl_pkg::IF_I2C;
          next_offered = next_activeIf;
          next_timer = 24'h000000;
          if (bootLevel && usbConnected)
          begin
            next_state = isl_pkg::ST_FWLOAD;
          end
          else if (modeLevel)
          begin
            next_state = isl_pkg::ST_HOLD;
          end
          else
          begin
            next_state = isl_pkg::ST_RUN;
          end
        end
      end
      isl_pkg::ST_HOLD:
      begin
        if (!modeLevel)
        begin
          next_state = isl_pkg::ST_OFFER;
        end
      end
      isl_pkg::ST_OFFER:
      begin
        next_timer = 24'h000000;
        if (modeLevel)
        begin
          next_state = isl_pkg::ST_PRESS;
        end
      end
      isl_pkg::ST_PRESS:
      begin
        if (timer >= HOLD_CYC - 24'h000001)
        begin
          next_state = isl_pkg::ST_COMMIT;
        end
        else if (!modeLevel)
        begin
          next_offered = isl_pkg::isl_if_t'(offered + 2'h1);
          next_state = isl_pkg::ST_OFFER;
        end
      end
      isl_pkg::ST_COMMIT:
      begin
        if (!modeLevel)
        begin
          next_state = isl_pkg::ST_WRITE;
          next_nvWriteReq = 1'b1;
          next_nvWriteData = offered;
        end
      end
      isl_pkg::ST_WRITE:
      begin
        next_nvWriteReq = ~nvDone;
        next_timer = 24'h000000;
        if (nvDone)
        begin
          next_activeIf = offered;
          next_state = isl_pkg::ST_SETTLE;
        end
      end
      isl_pkg::ST_SETTLE:
      begin
        if (timer >= SETTLE_CYC - 24'h000001)
        begin
          next_state = isl_pkg::ST_RUN;
        end
      end
      isl_pkg::ST_RUN:
      begin
        next_timer = 24'h000000;
      end
      isl_pkg::ST_FWLOAD:
      begin
        next_fwLoadMode = 1'b1;
        if (fwLoadDone)
        begin
          next_state = isl_pkg::ST_BOOT;
          next_fwLoadMode = 1'b0;
          next_timer = 24'h000000;
        end
      end
      default:
      begin
        next_state = isl_pkg::ST_BOOT;
      end
    endcase
    if (!extSync2)
    begin
      next_state = isl_pkg::ST_BOOT;
      next_timer = 24'h000000;
      next_nvReadReq = 1'b0;
      next_nvWriteReq = 1'b0;
      next_fwLoadMode = 1'b0;
      next_seen = 1'b0;
      next_errFlag = 1'b0;
      next_recent = 24'h000000;
    end
    next_ifEnable = 4'h1 << next_activeIf;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= isl_pkg::ST_BOOT;
      timer <= 24'h000000;
      activeIf <= isl_pkg::IF_I2C;
      offered <= isl_pkg::IF_I2C;
      nvReadReq <= 1'b0;
      nvWriteReq <= 1'b0;
      nvWriteData <= 2'h0;
      fwLoadMode <= 1'b0;
      ifEnable <= 4'h1;
      seen <= 1'b0;
      errFlag <= 1'b0;
      recent <= 24'h000000;
      extSync1 <= 1'b0;
      extSync2 <= 1'b0;
    end
    else
    begin
      state <= next_state;
      timer <= next_timer;
      activeIf <= next_activeIf;
      offered <= next_offered;
      nvReadReq <= next_nvReadReq;
      nvWriteReq <= next_nvWriteReq;
      nvWriteData <= next_nvWriteData;
      fwLoadMode <= next_fwLoadMode;
      ifEnable <= next_ifEnable;
      seen <= next_seen;
      errFlag <= next_errFlag;
      recent <= next_recent;
      extSync1 <= extRst_n;
      extSync2 <= extSync1;
    end
  end

  // ==========================================================
  // LED pattern choice and sequencer
  always_comb
  begin
    pat = '{kind: isl_pkg::PAT_OFF, count: 3'h0, half: BLINK_CYC};
    case (state)
      isl_pkg::ST_HOLD, isl_pkg::ST_COMMIT:
      begin
        pat.kind = isl_pkg::PAT_SOLID;
      end
      isl_pkg::ST_OFFER, isl_pkg::ST_PRESS:
      begin
        pat.kind = isl_pkg::PAT_BURST;
        pat.count = {1'b0, offered} + 3'h1;
      end
      isl_pkg::ST_RUN:
      begin
        pat.kind = isl_pkg::PAT_FLASH;
        if (errFlag)
        begin
          pat.half = HALF_ERR;
        end
        else if (recent != 24'h000000)
        begin
          pat.half = HALF_FAST;
        end
        else if (seen)
        begin
          pat.half = HALF_SLOW;
        end
        else
        begin
          pat.kind = isl_pkg::PAT_BURST;
          pat.count = {1'b0, activeIf} + 3'h1;
        end
      end
      default:
      begin
        pat.kind = isl_pkg::PAT_OFF;
      end
    endcase
  end

  always_comb
  begin
    next_ledTimer = ledTimer + 24'h000001;
    next_ledStep = ledStep;
    next_led = 1'b0;
    if (pat != prevPat)
    begin
      next_ledTimer = 24'h000000;
      next_ledStep = 4'h0;
    end
    else if (pat.kind == isl_pkg::PAT_FLASH &&
             ledTimer >= pat.half - 24'h000001)
    begin
      next_ledTimer = 24'h000000;
      next_ledStep = ledStep ^ 4'h1;
    end
    else if (pat.kind == isl_pkg::PAT_BURST)
    begin
      if (ledStep == {pat.count, 1'b0})
      begin
        if (ledTimer >= PAUSE_CYC - 24'h000001)
        begin
          next_ledTimer = 24'h000000;
          next_ledStep = 4'h0;
        end
      end
      else if (ledTimer >= BLINK_CYC - 24'h000001)
      begin
        next_ledTimer = 24'h000000;
        next_ledStep = ledStep + 4'h1;
      end
    end
    case (pat.kind)
      isl_pkg::PAT_SOLID: next_led = 1'b1;
      isl_pkg::PAT_FLASH: next_led = ~next_ledStep[0];
      isl_pkg::PAT_BURST:
        next_led = ~next_ledStep[0] && next_ledStep < {pat.count, 1'b0};
      default: next_led = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prevPat <= '{kind: isl_pkg::PAT_OFF, count: 3'h0, half: 24'h000000};
      ledTimer <= 24'h000000;
      ledStep <= 4'h0;
      led <= 1'b0;
    end
    else
    begin
      prevPat <= pat;
      ledTimer <= next_ledTimer;
      ledStep <= next_ledStep;
      led <= next_led;
    end
  end

  // ==========================================================
  // Shared header pin routing, drivers idle unless owned
  always_comb
  begin
    next_pins.drive = 4'h0;
    next_pins.oeN = 4'hF;
    next_coreIn = '{sdaIn: 1'b1, sclIn: 1'b1, spiSck: 1'b0,
                    spiCs: 1'b1, spiMosi: 1'b0, uartRx: 1'b1};
    case (activeIf)
      isl_pkg::IF_I2C:
      begin
        next_pins.oeN[isl_pkg::PIN_SCK_SDA] = ~coreOut.sdaLow;
        next_pins.oeN[isl_pkg::PIN_MISO_SCL] = ~coreOut.sclLow;
        next_coreIn.sdaIn = pinIn[isl_pkg::PIN_SCK_SDA];
        next_coreIn.sclIn = pinIn[isl_pkg::PIN_MISO_SCL];
      end
      isl_pkg::IF_SPI:
      begin
        next_pins.drive[isl_pkg::PIN_MISO_SCL] = coreOut.spiMiso;
        next_pins.oeN[isl_pkg::PIN_MISO_SCL] = pinIn[isl_pkg::PIN_CS_URX];
        next_coreIn.spiSck = pinIn[isl_pkg::PIN_SCK_SDA];
        next_coreIn.spiCs = pinIn[isl_pkg::PIN_CS_URX];
        next_coreIn.spiMosi = pinIn[isl_pkg::PIN_MOSI_UTX];
      end
      isl_pkg::IF_UART:
      begin
        next_pins.drive[isl_pkg::PIN_MOSI_UTX] = coreOut.uartTx;
        next_pins.oeN[isl_pkg::PIN_MOSI_UTX] = 1'b0;
        next_coreIn.uartRx = pinIn[isl_pkg::PIN_CS_URX];
      end
      default:
      begin
        next_pins.oeN = 4'hF;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pins <= '{drive: 4'h0, oeN: 4'hF};
      coreIn <= '{sdaIn: 1'b1, sclIn: 1'b1, spiSck: 1'b0,
                  spiCs: 1'b1, spiMosi: 1'b0, uartRx: 1'b1};
    end
    else
    begin
      pins <= next_pins;
      coreIn <= next_coreIn;
    end
  end

  // ==========================================================
  // Checks
  sequence commitRelease;
    state == isl_pkg::ST_COMMIT && !modeLevel;
  endsequence

  sequence writeStarts;
    state == isl_pkg::ST_WRITE && nvWriteReq && nvWriteData == offered;
  endsequence

  oneHotIf_a: assert property ($onehot(ifEnable))
    else $error("interface enable not one-hot");
  loadStored_a: assert property (
    state == isl_pkg::ST_BOOT && next_state != isl_pkg::ST_BOOT && nvValid
    |=> activeIf == $past(nvData) ##1 ifEnable == (4'h1 << activeIf))
    else $error("stored interface not applied");
  blankI2c_a: assert property (
    state == isl_pkg::ST_BOOT && next_state != isl_pkg::ST_BOOT && !nvValid
    |=> activeIf == isl_pkg::IF_I2C)
    else $error("blank storage did not pick I2C");
  holdLed_a: assert property (
    state == isl_pkg::ST_HOLD [*2] |-> led)
    else $error("LED not steady while button held");
  wrapUsb_a: assert property (
    state == isl_pkg::ST_PRESS && offered == isl_pkg::IF_USB &&
    next_state == isl_pkg::ST_OFFER |=> offered == isl_pkg::IF_I2C)
    else $error("offer did not wrap to I2C");
  commitLed_a: assert property (
    state == isl_pkg::ST_COMMIT [*2] |-> led)
    else $error("LED not solid on commit");
  storeChoice_a: assert property (
    commitRelease |=> writeStarts)
    else $error("commit release did not start store");
  fwLedOff_a: assert property (
    fwLoadMode ##1 fwLoadMode |-> !led)
    else $error("LED lit during firmware load");
  uartPin_a: assert property (
    activeIf == isl_pkg::IF_UART && $stable(activeIf)
    |=> !pins.oeN[isl_pkg::PIN_MOSI_UTX] && pins.oeN[isl_pkg::PIN_SCK_SDA])
    else $error("UART pin routing wrong");

endmodule : isl_status_top

/* tb/isl_nv_model.sv */
// Non-volatile storage model answering the block's read and write requests
`timescale 1ns/1ps
module isl_nv_model (
  // Clock
  input wire logic clk,
  // Requests from the block
  input wire logic nvReadReq,
  input wire logic nvWriteReq,
  input wire logic [1:0] nvWriteData,
  // Answer latency in cycles
  input wire logic [3:0] lat,
  // Answer to the block
  output logic nvDone,
  output logic nvValid,
  output logic [1:0] nvData
);
  // Storage survives every reset, so no reset input
  logic [1:0] store = 2'h0;
  logic stored = 1'b0;
  logic [1:0] phase = 2'h0;
  logic [3:0] cnt = 4'h0;

  initial
  begin
    nvDone = 1'b0;
    nvValid = 1'b1;
    nvData = 2'h3;
  end

  // ==========================================================
  // Handshake; data lines show the inverse outside the answer
  always @(posedge clk)
  begin
    nvDone <= 1'b0;
    nvValid <= ~stored;
    nvData <= ~store;
    if (phase == 2'h2)
      phase <= 2'h0;
    else if (phase == 2'h1 && cnt != 4'h0)
      cnt <= cnt - 4'h1;
    else if (phase == 2'h1)
    begin
      nvDone <= 1'b1;
      nvValid <= stored;
      nvData <= store;
      phase <= 2'h2;
      if (nvWriteReq)
      begin
        store <= nvWriteData;
        stored <= 1'b1;
      end
    end
    else if (nvReadReq || nvWriteReq)
    begin
      phase <= 2'h1;
      cnt <= lat;
    end
  end
endmodule : isl_nv_model

/* tb/tb_top.sv */
// Self-checking testbench for interface selection and status LED
`timescale 1ns/1ps
module tb_top;
  localparam int HF = 7;
  localparam int HS = 20;
  localparam int HE = 5;
  typedef struct packed {
    logic [3:0] sel;
    logic [7:0] exp;
  } isl_note_t;

  logic clk, rst, extRst_n, modeButton, boot_select_button;
  logic usbConnected, busActivity, errorDetect, fwLoadDone;
  logic nvDone, nvValid, nvReadReq, nvWriteReq;
  logic [1:0] nvData, nvWriteData;
  logic [3:0] pinIn, ifEnable, lat;
  logic led, fwLoadMode;
  isl_pkg::isl_core_out_t coreOut;
  isl_pkg::isl_core_in_t coreIn;
  isl_pkg::isl_pins_t pins;
  isl_note_t notes[$];
  isl_note_t note;
  logic [7:0] meas, got;
  integer seed;
  int fail_count, checks, cyc, i;
  event look;

  isl_status_top #(.DEB_CYC(24'h000004), .HOLD_CYC(24'h000028),
    .BLINK_CYC(24'h000003), .PAUSE_CYC(24'h00000A),
    .SETTLE_CYC(24'h000005), .RECENT_CYC(24'h000032),
    .HALF_FAST(24'(HF)), .HALF_SLOW(24'(HS)), .HALF_ERR(24'(HE))
  ) u_dut (.clk(clk), .rst(rst), .extRst_n(extRst_n),
    .modeButton(modeButton), .boot_select_button(boot_select_button),
    .usbConnected(usbConnected), .busActivity(busActivity),
    .errorDetect(errorDetect), .fwLoadDone(fwLoadDone), .nvDone(nvDone),
    .nvValid(nvValid), .nvData(nvData), .nvReadReq(nvReadReq),
    .nvWriteReq(nvWriteReq), .nvWriteData(nvWriteData),
    .coreOut(coreOut), .coreIn(coreIn), .pinIn(pinIn), .pins(pins),
    .led(led), .ifEnable(ifEnable), .fwLoadMode(fwLoadMode));

  isl_nv_model u_nv (.clk(clk), .nvReadReq(nvReadReq),
    .nvWriteReq(nvWriteReq), .nvWriteData(nvWriteData), .lat(lat),
    .nvDone(nvDone), .nvValid(nvValid), .nvData(nvData));

  always #50 clk = ~clk;

  // ==========================================================
  // Result watcher
  function automatic logic [7:0] probe(input logic [3:0] s);
    case (s)
      4'h0: probe = {4'h0, ifEnable};
      4'h1: probe = {7'h00, led};
      4'h2: probe = {6'h00, nvWriteData};
      4'h3: probe = {7'h00, fwLoadMode};
      4'h4: probe = {4'h0, pins.oeN};
      4'h5: probe = {2'h0, coreIn};
      4'h7: probe = {7'h00, pins.drive[1]};
      4'h8: probe = {4'h0, pins.drive};
      default: probe = meas;
    endcase
  endfunction : probe

  always @(look)
  begin
    note = notes.pop_front();
    got = probe(note.sel);
    checks++;
    if (got !== note.exp)
    begin
      fail_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, note.exp);
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Stimulus tasks
  task automatic note_exp(input logic [3:0] s, input logic [7:0] e);
    @(negedge clk);
    notes.push_back('{s, e});
    ->look;
  endtask : note_exp

  task automatic power_up(input logic m, input logic b);
    @(posedge clk);
    rst <= 1'b1;
    modeButton <= m;
    boot_select_button <= b;
    usbConnected <= b | 1'($random(seed));
    lat <= 4'($random(seed));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (30) @(posedge clk);
  endtask : power_up

  task automatic press(input int n);
    @(posedge clk);
    modeButton <= 1'b1;
    repeat (n) @(posedge clk);
    modeButton <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : press

  // Blinks in one burst, counted from the end of a pause
  task automatic count_burst();
    int low, n, t;
    low = 0;
    n = 0;
    for (t = 0; t < 400 && low < 6; t++)
    begin
      @(negedge clk);
      low = (led === 1'b0) ? low + 1 : 0;
    end
    // Skip the rest of the pause up to the first blink
    for (t = 0; t < 400 && led !== 1'b1; t++) @(negedge clk);
    low = 1;
    for (t = 0; t < 400 && low < 6; t++)
    begin
      @(negedge clk);
      if (led === 1'b1 && low > 0)
        n++;
      low = (led === 1'b0) ? low + 1 : 0;
    end
    meas = 8'(n);
  endtask : count_burst

  // Length of one lit phase of a flash
  task automatic half_run();
    int t;
    for (t = 0; t < 200 && led !== 1'b0; t++) @(negedge clk);
    for (t = 0; t < 200 && led !== 1'b1; t++) @(negedge clk);
    for (t = 0; t < 200 && led === 1'b1; t++) @(negedge clk);
    meas = 8'(t);
  endtask : half_run

  // ==========================================================
  // Main sequence
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    extRst_n = 1'b1;
    {modeButton, boot_select_button, usbConnected} = 3'h0;
    {busActivity, errorDetect, fwLoadDone} = 3'h0;
    pinIn = 4'hF;
    coreOut = 4'hF;
    lat = 4'h3;
    seed = 32'h9A39D32C;
    power_up(1'b0, 1'b0);
    note_exp(4'h0, 8'h01);
    count_burst();
    note_exp(4'h6, 8'h01);
    power_up(1'b1, 1'b0);
    note_exp(4'h1, 8'h01);
    @(posedge clk);
    modeButton <= 1'b0;
    count_burst();
    note_exp(4'h6, 8'h01);
    for (i = 0; i < 5; i++)
    begin
      press(10);
      count_burst();
      note_exp(4'h6, 8'((i + 1) % 4 + 1));
    end
    // Operator holds the button to commit
    @(posedge clk);
    modeButton <= 1'b1;
    repeat (60) @(posedge clk);
    for (i = 0; i < 4; i++)
      note_exp(4'h1, 8'h01);
    @(posedge clk);
    modeButton <= 1'b0;
    for (i = 0; i < 100 && nvWriteReq !== 1'b1; i++) @(negedge clk);
    note_exp(4'h2, 8'h01);
    repeat (40) @(posedge clk);
    note_exp(4'h0, 8'h02);
    count_burst();
    note_exp(4'h6, 8'h02);
    // Pin routing in SPI mode
    @(posedge clk);
    pinIn <= 4'($random(seed)) & 4'hB;
    coreOut <= isl_pkg::isl_core_out_t'(4'($random(seed)));
    repeat (3) @(posedge clk);
    note_exp(4'h4, 8'h0D);
    note_exp(4'h7, {7'h00, coreOut.spiMiso});
    note_exp(4'h5, {2'h3, pinIn[0], pinIn[2], pinIn[3], 1'b1});
    @(posedge clk);
    pinIn <= pinIn | 4'h4;
    repeat (3) @(posedge clk);
    note_exp(4'h4, 8'h0F);
    // Flash rates
    @(posedge clk);
    busActivity <= 1'b1;
    @(posedge clk);
    busActivity <= 1'b0;
    half_run();
    note_exp(4'h6, 8'(HF));
    repeat (60) @(posedge clk);
    half_run();
    note_exp(4'h6, 8'(HS));
    @(posedge clk);
    errorDetect <= 1'b1;
    @(posedge clk);
    errorDetect <= 1'b0;
    half_run();
    note_exp(4'h6, 8'(HE));
    // External reset clears the sticky error
    @(posedge clk);
    extRst_n <= 1'b0;
    repeat (3) @(posedge clk);
    extRst_n <= 1'b1;
    repeat (40) @(posedge clk);
    note_exp(4'h0, 8'h02);
    count_burst();
    note_exp(4'h6, 8'h02);
    // Firmware load
    @(posedge clk);
    usbConnected <= 1'b1;
    power_up(1'b0, 1'b1);
    note_exp(4'h3, 8'h01);
    for (i = 0; i < 4; i++)
      note_exp(4'h1, 8'h00);
    @(posedge clk);
    boot_select_button <= 1'b0;
    fwLoadDone <= 1'b1;
    @(posedge clk);
    fwLoadDone <= 1'b0;
    repeat (40) @(posedge clk);
    note_exp(4'h3, 8'h00);
    count_burst();
    note_exp(4'h6, 8'h02);
    // Second selection commits UART
    power_up(1'b1, 1'b0);
    @(posedge clk);
    modeButton <= 1'b0;
    count_burst();
    note_exp(4'h6, 8'h02);
    press(10);
    count_burst();
    note_exp(4'h6, 8'h03);
    @(posedge clk);
    modeButton <= 1'b1;
    repeat (60) @(posedge clk);
    modeButton <= 1'b0;
    pinIn <= 4'($random(seed));
    coreOut <= isl_pkg::isl_core_out_t'(4'($random(seed)));
    repeat (60) @(posedge clk);
    note_exp(4'h2, 8'h02);
    note_exp(4'h0, 8'h04);
    note_exp(4'h4, 8'h07);
    note_exp(4'h8, {4'h0, coreOut.uartTx, 3'h0});
    note_exp(4'h5, {7'h1A, pinIn[2]});
    tally_and_finish();
  end
endmodule : tb_top
